//--- common/cbf_defs.vh
`ifndef CBF_DEFS_VH
`define CBF_DEFS_VH

// Register byte addresses
`define CBF_ADDR_MSKSRC 4'h0
`define CBF_ADDR_MSKCON 4'h4
`define CBF_ADDR_FLTR 4'h8
`define CBF_ADDR_STAT 4'hC

// Reset values and write masks
`define CBF_RST_16 16'h0000
`define CBF_MSKSRC_MASK 16'h0FFF
`define CBF_MSKCON_MASK 16'hBFFF
`define CBF_FLTR_MASK 16'h007F

// Mask source fields
`define CBF_SRC_A 3:0
`define CBF_SRC_B 7:4
`define CBF_SRC_C 11:8

// Mask gating bits
`define CBF_AND_A_INV 0
`define CBF_AND_A_TRUE 1
`define CBF_AND_B_INV 2
`define CBF_AND_B_TRUE 3
`define CBF_AND_C_INV 4
`define CBF_AND_C_TRUE 5
`define CBF_AND_OUT 6
`define CBF_AND_OUT_INV 7
`define CBF_OR_A_INV 8
`define CBF_OR_A_TRUE 9
`define CBF_OR_B_INV 10
`define CBF_OR_B_TRUE 11
`define CBF_OR_C_INV 12
`define CBF_OR_C_TRUE 13
`define CBF_BLANK_LEVEL 15

// Filter control fields
`define CBF_DIV 2:0
`define CBF_FILTER_ON 3
`define CBF_CLK_SRC 6:4

// Filter clock source codes
`define CBF_CS_PERIPH 3'h0
`define CBF_CS_OSC 3'h1
`define CBF_CS_SYNC1 3'h2
`define CBF_CS_SYNC2 3'h3
`define CBF_CS_T2 3'h4
`define CBF_CS_T3 3'h5
`define CBF_CS_T4 3'h6
`define CBF_CS_T5 3'h7

`endif

//--- design/cbf_glitch_filter.v
`timescale 1ns/100ps
`include "cbf_defs.vh"

module cbf_glitch_filter #(
	parameter DIV_W = 8
) (
	input wire sys_clk_in, // System clock
	input wire rst_n_in, // Synchronised reset, active low
	input wire [7:0] src_ticks_in, // Candidate filter clock levels
	input wire [2:0] clock_source_in, // Filter clock selector
	input wire [2:0] clock_divider_in, // Divider code
	input wire sample_in, // Signal to be filtered
	output reg filtered_out // Filtered level
);

	// ****************************************
	// Clock select, edge detect and divider
	// ****************************************
	reg src_q;
	reg [DIV_W-1:0] div_q;
	reg [2:0] hist_q;
	wire src_d = src_ticks_in[clock_source_in];
	wire src_rise = src_d & ~src_q;
	wire [DIV_W-1:0] div_d = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
	// Code n divides by 2^(n+1); the top code wraps the count
	wire [DIV_W-1:0] div_last = ({{(DIV_W-2){1'b0}}, 2'b10} << clock_divider_in) -
		{{(DIV_W-1){1'b0}}, 1'b1};
	// A count left beyond the last value by a code change samples on the next source rise
	wire tick = src_rise & (div_q >= div_last);
	wire [DIV_W-1:0] div_nx = tick ? {DIV_W{1'b0}} : (src_rise ? div_d : div_q);

	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			src_q <= 1'b0;
			div_q <= {DIV_W{1'b0}};
			hist_q <= 3'h0;
			filtered_out <= 1'b0;
		end else begin
			src_q <= src_d;
			div_q <= div_nx;
			if (tick) begin
				hist_q <= {hist_q[1:0], sample_in};
				// Three agreeing samples move the output
				if (hist_q[1:0] == {2{sample_in}})
					filtered_out <= sample_in;
			end
		end
	end

endmodule // cbf_glitch_filter

//--- design/cbf_comparator_blanking.v
`timescale 1ns/100ps
`include "cbf_defs.vh"

module cbf_comparator_blanking (
	input wire sys_clk_in, // 200 MHz clock
	input wire rstn_in, // Async reset, active low
	input wire wb_cyc_in, // Wishbone cycle
	input wire wb_stb_in, // Wishbone strobe
	input wire wb_we_in, // Wishbone write enable
	input wire [3:0] wb_adr_in, // Wishbone byte address
	input wire [3:0] wb_sel_in, // Wishbone byte selects
	input wire [31:0] wb_dat_in, // Wishbone write data
	output reg [31:0] wb_dat_out, // Wishbone read data
	output reg wb_ack_out, // Wishbone acknowledge
	input wire comp_raw_in, // Raw comparator, high when plus above minus
	input wire output_invert_in, // Invert comparator sense
	input wire [15:0] mask_sources_in, // Fault, trigger and PWM signals
	input wire peripheral_clock_in, // Filter clock source 0
	input wire oscillator_clock_in, // Filter clock source 1
	input wire pwm_sync_out_1_in, // Filter clock source 2
	input wire pwm_sync_out_2_in, // Filter clock source 3
	input wire timer2_clock_in, // Filter clock source 4
	input wire timer3_clock_in, // Filter clock source 5
	input wire timer4_clock_in, // Filter clock source 6
	input wire timer5_clock_in, // Filter clock source 7
	output reg comp_out, // Blanked and filtered comparator output
	output reg blank_active_out // Blanking signal
);

	// ****************************************
	// Reset synchroniser
	// ****************************************
	reg rst_meta_q;
	reg rst_sync_q;
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	reg [15:0] msksrc_q;
	reg [15:0] mskcon_q;
	reg [15:0] fltr_q;
	wire comp_level = comp_raw_in ^ output_invert_in;
	wire filt_level;
	wire req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	wire wr = req & wb_we_in;
	wire [15:0] wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

	function [15:0] merge;
		input [15:0] old_v;
		input [15:0] new_v;
		input [15:0] lanes;
		input [15:0] impl;
		begin
			merge = ((old_v & ~lanes) | (new_v & lanes)) & impl;
		end
	endfunction

	always @(posedge sys_clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			msksrc_q <= `CBF_RST_16;
			mskcon_q <= `CBF_RST_16;
			fltr_q <= `CBF_RST_16;
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= req;
			if (wr && wb_adr_in == `CBF_ADDR_MSKSRC)
				msksrc_q <= merge(msksrc_q, wb_dat_in[15:0], wmask, `CBF_MSKSRC_MASK);
			if (wr && wb_adr_in == `CBF_ADDR_MSKCON)
				mskcon_q <= merge(mskcon_q, wb_dat_in[15:0], wmask, `CBF_MSKCON_MASK);
			if (wr && wb_adr_in == `CBF_ADDR_FLTR)
				fltr_q <= merge(fltr_q, wb_dat_in[15:0], wmask, `CBF_FLTR_MASK);
			if (req) begin
				case (wb_adr_in)
				`CBF_ADDR_MSKSRC: wb_dat_out <= {16'h0000, msksrc_q};
				`CBF_ADDR_MSKCON: wb_dat_out <= {16'h0000, mskcon_q};
				`CBF_ADDR_FLTR: wb_dat_out <= {16'h0000, fltr_q};
				`CBF_ADDR_STAT: wb_dat_out <= {29'h0000000, blank_active_out,
					filt_level, comp_level};
				default: wb_dat_out <= 32'h00000000;
				endcase
			end
		end
	end

	// ****************************************
	// Comparator sense and mask gating
	// ****************************************
	wire mask_input_a = mask_sources_in[msksrc_q[`CBF_SRC_A]];
	wire mask_input_b = mask_sources_in[msksrc_q[`CBF_SRC_B]];
	wire mask_input_c = mask_sources_in[msksrc_q[`CBF_SRC_C]];

	// Any enabled term, true or inverted; no enables gives no term
	function term_any;
		input sig;
		input en_true;
		input en_inv;
		begin
			term_any = (en_true & sig) | (en_inv & ~sig);
		end
	endfunction

	// AND product term: cleared enables leave the term out (reads as one)
	function term_and;
		input sig;
		input en_true;
		input en_inv;
		begin
			term_and = (~en_true | sig) & (~en_inv | ~sig);
		end
	endfunction

	wire and_used = |mskcon_q[`CBF_AND_C_TRUE:`CBF_AND_A_INV];
	wire and_out = and_used &
		term_and(mask_input_a, mskcon_q[`CBF_AND_A_TRUE], mskcon_q[`CBF_AND_A_INV]) &
		term_and(mask_input_b, mskcon_q[`CBF_AND_B_TRUE], mskcon_q[`CBF_AND_B_INV]) &
		term_and(mask_input_c, mskcon_q[`CBF_AND_C_TRUE], mskcon_q[`CBF_AND_C_INV]);
	wire blank_d =
		term_any(mask_input_a, mskcon_q[`CBF_OR_A_TRUE], mskcon_q[`CBF_OR_A_INV]) |
		term_any(mask_input_b, mskcon_q[`CBF_OR_B_TRUE], mskcon_q[`CBF_OR_B_INV]) |
		term_any(mask_input_c, mskcon_q[`CBF_OR_C_TRUE], mskcon_q[`CBF_OR_C_INV]) |
		(mskcon_q[`CBF_AND_OUT] & and_out) |
		(mskcon_q[`CBF_AND_OUT_INV] & and_used & ~and_out);

	// ****************************************
	// Digital filter
	// ****************************************
	cbf_glitch_filter #(
		.DIV_W(8)
	) u_filter (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_sync_q),
		.src_ticks_in({timer5_clock_in, timer4_clock_in, timer3_clock_in, timer2_clock_in,
			pwm_sync_out_2_in, pwm_sync_out_1_in, oscillator_clock_in,
			peripheral_clock_in}),
		.clock_source_in(fltr_q[`CBF_CLK_SRC]),
		.clock_divider_in(fltr_q[`CBF_DIV]),
		.sample_in(comp_level),
		.filtered_out(filt_level)
	);

	wire sel_level = fltr_q[`CBF_FILTER_ON] ? filt_level : comp_level;
	// Blocked level held at the idle value while blanking
	wire blanked = mskcon_q[`CBF_BLANK_LEVEL] ? 1'b1 : 1'b0;
	wire hit = blank_d & (sel_level == ~blanked);

	always @(posedge sys_clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			comp_out <= 1'b0;
			blank_active_out <= 1'b0;
		end else begin
			comp_out <= hit ? blanked : sel_level;
			blank_active_out <= blank_d;
		end
	end

endmodule // cbf_comparator_blanking

//--- verification/cbf_comparator_blanking_chk.sv
`timescale 1ns/100ps
// ****************
// Port checker
// ****************
module cbf_comparator_blanking_chk (
	input wire sys_clk_in, // Clock
	input wire rstn_in, // Reset
	input wire wb_cyc_in, // Cycle
	input wire wb_stb_in, // Strobe
	input wire wb_we_in, // Write
	input wire [3:0] wb_adr_in, // Address
	input wire [3:0] wb_sel_in, // Lanes
	input wire [31:0] wb_dat_in, // Write data
	input wire [31:0] wb_dat_out, // Read data
	input wire wb_ack_out, // Ack
	input wire comp_raw_in, // Comparator
	input wire output_invert_in, // Invert
	input wire comp_out, // Output
	input wire blank_active_out // Blanking
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	logic [2:0] up_q;
	logic cfg_q, hl_q;
	// Settling, any write seen, blocked level
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			{up_q, cfg_q, hl_q} <= 5'h00;
		end else begin
			up_q <= {up_q[1:0], 1'b1};
			cfg_q <= cfg_q | (wb_cyc_in & wb_stb_in & wb_we_in);
			if (wb_cyc_in & wb_stb_in & !wb_ack_out & wb_we_in & wb_sel_in[1] & (wb_adr_in == 4'h4))
				hl_q <= wb_dat_in[15];
		end
	end
	property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_ack_lat; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack late");
	property p_ack_cause; wb_ack_out |-> $past(wb_cyc_in && wb_stb_in); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_rst; disable iff (1'b0) !rstn_in |-> !wb_ack_out && !comp_out && !blank_active_out; endproperty
	a_rst: assert property (p_rst) else $error("outputs active in reset");
	property p_rd_src; wb_ack_out && $past(!wb_we_in && wb_adr_in == 4'h0) |-> wb_dat_out[31:12] == 20'h00000; endproperty
	a_rd_src: assert property (p_rd_src) else $error("source select spare bits");
	property p_rd_con; wb_ack_out && $past(!wb_we_in && wb_adr_in == 4'h4) |-> wb_dat_out[31:16] == 16'h0000 && !wb_dat_out[14]; endproperty
	a_rd_con: assert property (p_rd_con) else $error("gating spare bits");
	property p_rd_flt; wb_ack_out && $past(!wb_we_in && wb_adr_in == 4'h8) |-> wb_dat_out[31:7] == 25'h0000000; endproperty
	a_rd_flt: assert property (p_rd_flt) else $error("filter spare bits");
	property p_rd_gap; wb_ack_out && $past(!wb_we_in && wb_adr_in[1:0] != 2'h0) |-> wb_dat_out == 32'h00000000; endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
	property p_idle; up_q[2] && !cfg_q |-> !blank_active_out && comp_out == $past(comp_raw_in ^ output_invert_in); endproperty
	a_idle: assert property (p_idle) else $error("default path wrong");
	property p_blank; blank_active_out |-> comp_out == $past(hl_q); endproperty
	a_blank: assert property (p_blank) else $error("blanked level wrong");
	c_read: cover property (wb_ack_out && !wb_we_in);
	c_blank: cover property (blank_active_out && comp_out);
	c_rise: cover property ($rose(comp_out));
endmodule // cbf_comparator_blanking_chk
bind cbf_comparator_blanking cbf_comparator_blanking_chk cbf_chk_inst (.sys_clk_in, .rstn_in,
	.wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
	.wb_ack_out, .comp_raw_in, .output_invert_in, .comp_out, .blank_active_out);

//--- verification/cbf_far_side.sv
`timescale 1ns/100ps
// ****************
// Comparator and mask source model
// ****************
module cbf_far_side (
	input wire sys_clk_in, // Clock
	input wire level_in, // Wanted comparator level
	input wire [15:0] mask_in, // Wanted mask levels
	output logic comp_raw_out, // Comparator output
	output logic [15:0] mask_sources_out, // Mask sources
	output logic [7:0] ticks_out // Source k rises each 2^(k+1) cycles
);
	logic [7:0] cnt_q = 8'h00;
	always @(posedge sys_clk_in) begin
		cnt_q <= cnt_q + 8'h01;
		comp_raw_out <= level_in;
		mask_sources_out <= mask_in;
	end
	assign ticks_out = cnt_q;
endmodule // cbf_far_side

//--- verification/tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
// ****************
// Bench
// ****************
module tb;
	logic sys_clk_in = 1'b0, rstn_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
	logic output_invert_in = 1'b0, lvl = 1'b0;
	logic [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'h3;
	logic [31:0] wb_dat_in = 32'h0;
	logic [15:0] msk = 16'h0000, src, con;
	wire [31:0] wb_dat_out;
	wire [15:0] mask_sources_in;
	wire [7:0] tk;
	wire wb_ack_out, comp_raw_in, comp_out, blank_active_out;
	logic [17:0] exp_q[$], msk_q[$];
	integer seed = 4, fails = 0, num_checks = 0, i;
	cbf_far_side cbf_far_side_inst (.sys_clk_in, .level_in(lvl), .mask_in(msk),
		.comp_raw_out(comp_raw_in), .mask_sources_out(mask_sources_in), .ticks_out(tk));
	cbf_comparator_blanking cbf_comparator_blanking_inst (.sys_clk_in, .rstn_in, .wb_cyc_in,
		.wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
		.comp_raw_in, .output_invert_in, .mask_sources_in, .comp_out, .blank_active_out,
		.peripheral_clock_in(tk[0]), .oscillator_clock_in(tk[1]), .pwm_sync_out_1_in(tk[2]),
		.pwm_sync_out_2_in(tk[3]), .timer2_clock_in(tk[4]), .timer3_clock_in(tk[5]),
		.timer4_clock_in(tk[6]), .timer5_clock_in(tk[7]));
	always #2.5 sys_clk_in = ~sys_clk_in;
	// Expected {blank, output, status} from selectors, gating and level
	function automatic logic [17:0] blank_model(input logic [15:0] s, g, m, input logic l);
		logic [5:0] v;
		logic a, b;
		v = {m[s[11:8]], !m[s[11:8]], m[s[7:4]], !m[s[7:4]], m[s[3:0]], !m[s[3:0]]};
		a = (g[5:0] != 6'h00) && ((v | ~g[5:0]) == 6'h3F);
		b = |(v & g[13:8]) | (g[6] & a) | (g[7] & !a & (g[5:0] != 6'h00));
		return {b, b ? g[15] : l, 13'h0000, b, 1'b0, l};
	endfunction
	task automatic bus(input logic w, input logic [3:0] a, input logic [17:0] d, m);
		@(posedge sys_clk_in);
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in} <= {2'b11, w, a};
		wb_dat_in <= {16'hFFFF, d[15:0]};
		if (!w) begin
			exp_q.push_back(d);
			msk_q.push_back(m);
		end
		do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
		{wb_cyc_in, wb_stb_in} <= 2'b00;
	endtask
	always @(posedge sys_clk_in) begin
		if (wb_ack_out === 1'b1 && !wb_we_in) begin
			`CHK({blank_active_out, comp_out, wb_dat_out[15:0]} & msk_q[0], exp_q[0] & msk_q[0])
			exp_q.pop_front();
			msk_q.pop_front();
		end
	end
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge sys_clk_in);
		fails++;
		results();
	end
	initial begin
		@(posedge sys_clk_in) rstn_in <= 1'b0;
		repeat (16) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		for (i = 0; i < 4; i++) begin
			{lvl, output_invert_in} <= i[1:0];
			repeat (4) @(posedge sys_clk_in);
			bus(1'b0, 4'hC, {1'b0, i[1] ^ i[0], 15'h0000, i[1] ^ i[0]}, 18'h3FFFD);
		end
		for (i = 0; i < 16; i++) bus(1'b0, i[3:0], 18'h00000, 18'h0FFFD);
		for (i = 0; i < 16; i++) bus(1'b1, i[3:0], 18'h0FFFF, 18'h00000);
		for (i = 0; i < 16; i++) bus(1'b0, i[3:0], {2'b11, i == 0 ? 16'h0FFF : i == 4 ? 16'hBFFF :
			i == 8 ? 16'h007F : i == 12 ? 16'h0004 : 16'h0000}, 18'h3FFFD);
		output_invert_in <= 1'b0;
		bus(1'b1, 4'h8, 18'h00000, 18'h00000);
		repeat (40) begin
			src = 16'($random(seed)) & 16'h0FFF;
			con = 16'($random(seed)) & 16'hBFFF;
			{msk, lvl} <= 17'($random(seed));
			bus(1'b1, 4'h0, {2'b00, src}, 18'h00000);
			bus(1'b1, 4'h4, {2'b00, con}, 18'h00000);
			repeat (4) @(posedge sys_clk_in);
			bus(1'b0, 4'hC, blank_model(src, con, msk, lvl), 18'h3FFFD);
		end
		bus(1'b1, 4'h4, 18'h00000, 18'h00000);
		for (i = 0; i < 8; i++) begin
			bus(1'b1, 4'h8, {11'h000, i[2:0], 1'b1, 3'(7 - i)}, 18'h00000);
			lvl <= 1'b0;
			repeat (1700) @(posedge sys_clk_in);
			lvl <= 1'b1;
			repeat (1000) @(posedge sys_clk_in);
			lvl <= 1'b0;
			repeat (10) @(posedge sys_clk_in);
			bus(1'b0, 4'hC, 18'h00000, 18'h3FFFF);
			lvl <= 1'b1;
			repeat (1700) @(posedge sys_clk_in);
			bus(1'b0, 4'hC, 18'h10003, 18'h3FFFF);
		end
		results();
	end
endmodule // tb
